// [include/dio_port_defines.svh]
// constants of the bytewise digital io port
`ifndef DIO_PORT_DEFINES_SVH
`define DIO_PORT_DEFINES_SVH

`define DIO_WIDTH 32
`define DIO_LANES 4
`define DIO_LANE_W 8
`define DIO_REG_W 64

// field positions
`define LANE_DIR_LSB 0
`define LINE_STD_BIT 0
`define SRC_SEL_LSB 0
`define SRC_SEL_W 6

// selector encodings
`define LINE_STD_CMOS 1'b0
`define LINE_STD_LVDS 1'b1
`define MODE_MANUAL 6'h00
`define MODE_SEQ_FIRST 6'h30
`define MODE_SEQ_LAST 6'h33

// reset values
`define LANE_DIR_RESET 4'h0
`define LINE_STD_RESET 1'b0
`define SRC_SEL_RESET 6'h00
`define DRIVEN_RESET 32'h0000_0000

`endif

// [include/dio_port_pkg.sv]
// types of the bytewise digital io port
package dio_port_pkg;

   typedef enum logic [4:0] {
      SRC_MANUAL = 5'b00001,
      SRC_SEQ1 = 5'b00010,
      SRC_SEQ2 = 5'b00100,
      SRC_SEQ3 = 5'b01000,
      SRC_SEQ4 = 5'b10000
   } out_source_e;

   typedef struct packed {
      logic lane_dir_we;
      logic line_std_we;
      logic src_sel_we;
      logic driven_we;
      logic [63:0] wdata;
   } reg_write_s;

   typedef struct packed {
      logic [63:0] lane_dir;
      logic [63:0] sampled;
      logic [63:0] line_std;
      logic [63:0] src_sel;
      logic [63:0] driven;
   } reg_read_s;

   typedef struct packed {
      logic [31:0] seq4;
      logic [31:0] seq3;
      logic [31:0] seq2;
      logic [31:0] seq1;
   } seq_values_s;

endpackage

// [design/out_source_mux.sv]
// registered selection of the port output value
`timescale 1ns/1ps
`include "dio_port_defines.svh"

module out_source_mux (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire dio_port_pkg::out_source_e source_i,
   input wire logic [`DIO_WIDTH-1:0] manual_i,
   input wire dio_port_pkg::seq_values_s seq_i,
   output logic [`DIO_WIDTH-1:0] value_o
);

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         value_o <= `DRIVEN_RESET;
      end else begin
         unique case (source_i)
            dio_port_pkg::SRC_MANUAL: value_o <= manual_i;
            dio_port_pkg::SRC_SEQ1: value_o <= seq_i.seq1;
            dio_port_pkg::SRC_SEQ2: value_o <= seq_i.seq2;
            dio_port_pkg::SRC_SEQ3: value_o <= seq_i.seq3;
            dio_port_pkg::SRC_SEQ4: value_o <= seq_i.seq4;
            default: value_o <= manual_i;
         endcase
      end
   end

endmodule

// [design/bytewise_dio_port.sv]
// bytewise digital io port: lane direction, sampling, output source and line standard
`timescale 1ns/1ps
`include "dio_port_defines.svh"

module bytewise_dio_port #(
   parameter int LANES = `DIO_LANES,
   parameter int LANE_W = `DIO_LANE_W
) (
   // clock and reset
   input wire logic SYS_CLK_I,
   input wire logic RST_N_I,
   // register access
   input wire dio_port_pkg::reg_write_s REG_WR_I,
   output dio_port_pkg::reg_read_s REG_RD_O,
   // channel sequencer output values
   input wire dio_port_pkg::seq_values_s SEQ_I,
   // digital lines
   input wire logic [`DIO_WIDTH-1:0] DIO_I,
   output logic [`DIO_WIDTH-1:0] DIO_O,
   output logic [`DIO_WIDTH-1:0] DIO_OE_N_O,
   // pad line standard
   output logic LINE_STD_O
);

   // elaboration-time refusal of lane layouts the logic cannot serve
   if (LANES * LANE_W != `DIO_WIDTH || LANES != `DIO_LANES) begin
      $error("lane layout must cover the 32-bit port as four bytes");
   end

   logic [LANES-1:0] lane_dir_reg;
   logic line_std_reg;
   logic [`SRC_SEL_W-1:0] src_sel_reg;
   dio_port_pkg::out_source_e src_reg;
   logic [`DIO_WIDTH-1:0] driven_reg;
   logic [`DIO_WIDTH-1:0] sampled_reg;
   logic [`DIO_WIDTH-1:0] oe_n_reg;
   logic [`DIO_WIDTH-1:0] port_value;
   logic [`SRC_SEL_W-1:0] src_sel_next;

   // expand one bit per lane to one bit per line
   function automatic logic [`DIO_WIDTH-1:0] lane_mask(input logic [LANES-1:0] dir);
      logic [`DIO_WIDTH-1:0] m;
      m = '0;
      for (int l = 0; l < LANES; l++) begin
         m[l*LANE_W +: LANE_W] = {LANE_W{dir[l]}};
      end
      return m;
   endfunction

   // documented mode value check
   function automatic logic mode_valid(input logic [63:0] v);
      return (v == 64'({`MODE_MANUAL})) ||
             (v >= 64'({`MODE_SEQ_FIRST}) && v <= 64'({`MODE_SEQ_LAST}));
   endfunction

   // mode value to output source
   function automatic dio_port_pkg::out_source_e mode_source(input logic [`SRC_SEL_W-1:0] v);
      dio_port_pkg::out_source_e s;
      s = dio_port_pkg::SRC_MANUAL;
      if (v == `MODE_SEQ_FIRST) s = dio_port_pkg::SRC_SEQ1;
      if (v == `MODE_SEQ_FIRST + 6'h01) s = dio_port_pkg::SRC_SEQ2;
      if (v == `MODE_SEQ_FIRST + 6'h02) s = dio_port_pkg::SRC_SEQ3;
      if (v == `MODE_SEQ_LAST) s = dio_port_pkg::SRC_SEQ4;
      return s;
   endfunction

   assign src_sel_next = REG_WR_I.wdata[`SRC_SEL_LSB +: `SRC_SEL_W];

   // direction register
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         lane_dir_reg <= `LANE_DIR_RESET;
      end else if (REG_WR_I.lane_dir_we) begin
         lane_dir_reg <= REG_WR_I.wdata[`LANE_DIR_LSB +: LANES];
      end
   end

   // line standard register
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         line_std_reg <= `LINE_STD_RESET;
      end else if (REG_WR_I.line_std_we) begin
         line_std_reg <= REG_WR_I.wdata[`LINE_STD_BIT];
      end
   end

   // mode register; bad values leave everything as it was
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         src_sel_reg <= `SRC_SEL_RESET;
         src_reg <= dio_port_pkg::SRC_MANUAL;
      end else if (REG_WR_I.src_sel_we && mode_valid(REG_WR_I.wdata)) begin
         src_sel_reg <= src_sel_next;
         src_reg <= mode_source(src_sel_next);
      end
   end

   // manual output value
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         driven_reg <= `DRIVEN_RESET;
      end else if (REG_WR_I.driven_we) begin
         driven_reg <= REG_WR_I.wdata[`DIO_WIDTH-1:0];
      end
   end

   // input sampling, driven lanes read as zero
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         sampled_reg <= '0;
      end else begin
         sampled_reg <= DIO_I & ~lane_mask(lane_dir_reg);
      end
   end

   // pin enables, low while driving
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         oe_n_reg <= '1;
      end else begin
         oe_n_reg <= ~lane_mask(lane_dir_reg);
      end
   end

   out_source_mux u_src_mux (
      .clk_i(SYS_CLK_I),
      .rst_n_i(RST_N_I),
      .source_i(src_reg),
      .manual_i(driven_reg),
      .seq_i(SEQ_I),
      .value_o(port_value)
   );

   assign DIO_O = port_value;
   assign DIO_OE_N_O = oe_n_reg;
   assign LINE_STD_O = line_std_reg;

   // one driver for the whole read struct
   assign REG_RD_O = '{lane_dir: 64'(lane_dir_reg), sampled: 64'(sampled_reg), line_std: 64'(line_std_reg),
                       src_sel: 64'(src_sel_reg), driven: 64'(driven_reg)};

   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!RST_N_I);

   property p_dir_write;
      REG_WR_I.lane_dir_we |=> lane_dir_reg == $past(REG_WR_I.wdata[LANES-1:0]);
   endproperty
   a_dir_write: assert property (p_dir_write) else $error("direction write not taken");

   property p_oe_follows_dir;
      REG_WR_I.lane_dir_we ##1 !REG_WR_I.lane_dir_we |=>
         DIO_OE_N_O == ~lane_mask($past(REG_WR_I.wdata[LANES-1:0], 2));
   endproperty
   a_oe_follows_dir: assert property (p_oe_follows_dir) else $error("enables do not follow lanes");

   property p_sample;
      ##1 REG_RD_O.sampled[31:0] == ($past(DIO_I) & ~lane_mask($past(lane_dir_reg)));
   endproperty
   a_sample: assert property (p_sample) else $error("sampled value wrong");

   property p_manual_drive;
      (src_reg == dio_port_pkg::SRC_MANUAL) |=> DIO_O == $past(driven_reg);
   endproperty
   a_manual_drive: assert property (p_manual_drive) else $error("manual value not driven");

   property p_line_std;
      REG_WR_I.line_std_we |=> LINE_STD_O == $past(REG_WR_I.wdata[0]);
   endproperty
   a_line_std: assert property (p_line_std) else $error("line standard not applied");

   property p_mode_zero;
      REG_WR_I.src_sel_we && REG_WR_I.wdata == 64'h0 |=>
         src_reg == dio_port_pkg::SRC_MANUAL ##1 DIO_O == $past(driven_reg);
   endproperty
   a_mode_zero: assert property (p_mode_zero) else $error("mode 0 not manual");

   property p_seq1;
      REG_WR_I.src_sel_we && REG_WR_I.wdata == 64'h30 |=> ##1 DIO_O == $past(SEQ_I.seq1);
   endproperty
   a_seq1: assert property (p_seq1) else $error("mode 48 not channel one");

   property p_seq4;
      (src_reg == dio_port_pkg::SRC_SEQ4) |=> DIO_O == $past(SEQ_I.seq4);
   endproperty
   a_seq4: assert property (p_seq4) else $error("channel four not driven");

   property p_bad_mode;
      REG_WR_I.src_sel_we && !mode_valid(REG_WR_I.wdata) |=> $stable(src_reg) && $stable(src_sel_reg);
   endproperty
   a_bad_mode: assert property (p_bad_mode) else $error("bad mode value changed source");

   c_lvds: cover property (REG_WR_I.line_std_we && REG_WR_I.wdata[0]);
   c_seq3: cover property (src_reg == dio_port_pkg::SRC_SEQ3);
   c_mixed_lanes: cover property (lane_dir_reg == 4'h5);
   c_bad_mode: cover property (REG_WR_I.src_sel_we && !mode_valid(REG_WR_I.wdata));

endmodule

// [tb/dio_far_end.sv]
// far-side equipment model: drives the lines that the port leaves free
`timescale 1ns/1ps

module dio_far_end (
   // port side
   input wire logic [31:0] dev_val_i,
   input wire logic [31:0] dev_oe_n_i,
   // far side
   input wire logic [31:0] ext_i,
   output logic [31:0] line_o
);
   // port wins where it drives, far side elsewhere
   always_comb begin
      for (int b = 0; b < 32; b++) begin
         line_o[b] = dev_oe_n_i[b] ? ext_i[b] : dev_val_i[b];
      end
   end
endmodule

// [tb/bytewise_digital_io_port_test.sv]
// self-checking bench of the bytewise digital io port
`timescale 1ns/1ps

module bytewise_digital_io_port_test;
   typedef struct {
      logic [3:0] dir;
      logic [31:0] drv;
      logic [31:0] ext;
      logic [31:0] oe_n;
      logic [31:0] smp;
   } row_s;
   row_s rows [6] = '{
      '{4'h0, 32'h1122_3344, 32'ha5a5_a5a5, 32'hffff_ffff, 32'ha5a5_a5a5},
      '{4'h1, 32'hcafe_f00d, 32'h1234_5678, 32'hffff_ff00, 32'h1234_5600},
      '{4'h8, 32'h0f0f_0f0f, 32'h8765_4321, 32'h00ff_ffff, 32'h0065_4321},
      '{4'h5, 32'h3c3c_c3c3, 32'hffff_ffff, 32'hff00_ff00, 32'hff00_ff00},
      '{4'ha, 32'h7777_1111, 32'h5a5a_5a5a, 32'h00ff_00ff, 32'h005a_005a},
      '{4'hf, 32'hdead_beef, 32'hffff_ffff, 32'h0000_0000, 32'h0000_0000}};
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   dio_port_pkg::reg_write_s reg_wr = '0;
   dio_port_pkg::reg_read_s reg_rd;
   dio_port_pkg::seq_values_s seq = {32'h4444_0004, 32'h3333_0003, 32'h2222_0002, 32'h1111_0001};
   logic [31:0] ext = 32'h0;
   logic [31:0] line;
   logic [31:0] dio_out;
   logic [31:0] dio_oe_n;
   logic line_std;
   int err_count = 0;
   int total_checks = 0;

   always #2.5 sys_clk = ~sys_clk;

   bytewise_dio_port bytewise_dio_port_i (
      .SYS_CLK_I(sys_clk), .RST_N_I(rst_n), .REG_WR_I(reg_wr), .REG_RD_O(reg_rd), .SEQ_I(seq),
      .DIO_I(line), .DIO_O(dio_out), .DIO_OE_N_O(dio_oe_n), .LINE_STD_O(line_std));

   dio_far_end dio_far_end_i (.dev_val_i(dio_out), .dev_oe_n_i(dio_oe_n), .ext_i(ext), .line_o(line));

   task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask

   // strobes in order dir, std, mode, driven
   task automatic wr(input logic [3:0] s, input logic [63:0] v);
      @(posedge sys_clk);
      #1 reg_wr = {s, v};
      @(posedge sys_clk);
      #1 reg_wr = '0;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask

   task automatic wrap_up;
      if (err_count == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk_reset;
      chk("oe_n", 64'hffff_ffff, {32'h0, dio_oe_n});
      chk("dio_o", 64'h0, {32'h0, dio_out});
      chk("line_std", 64'h0, {63'h0, line_std});
      chk("src_sel", 64'h0, reg_rd.src_sel);
   endtask

   initial begin
      #5000;
      err_count++;
      wrap_up();
   end

   initial begin
      repeat (5) @(posedge sys_clk);
      #1 rst_n = 1'b1;
      chk_reset();
      foreach (rows[i]) begin
         ext = rows[i].ext;
         wr(4'h8, {60'h0, rows[i].dir});
         wr(4'h1, {32'h0, rows[i].drv});
         chk("lane_dir", {60'h0, rows[i].dir}, reg_rd.lane_dir);
         chk("oe_n", {32'h0, rows[i].oe_n}, {32'h0, dio_oe_n});
         chk("sampled", {32'h0, rows[i].smp}, reg_rd.sampled);
         chk("dio_o", {32'h0, rows[i].drv}, {32'h0, dio_out});
         chk("driven_rd", {32'h0, rows[i].drv}, reg_rd.driven);
      end
      for (int v = 1; v >= 0; v--) begin
         wr(4'h4, 64'(v));
         chk("line_std", 64'(v), {63'h0, line_std});
         chk("std_rd", 64'(v), reg_rd.line_std);
      end
      for (int m = 48; m <= 51; m++) begin
         wr(4'h2, 64'(m));
         chk("src_sel", 64'(m), reg_rd.src_sel);
         chk("dio_seq", {32'h0, seq[32*(m-48) +: 32]}, {32'h0, dio_out});
      end
      seq.seq4 = 32'h0bad_cafe;
      wr(4'h2, 64'd52);
      chk("src_keep", 64'd51, reg_rd.src_sel);
      wr(4'h2, 64'h1_0000_0030);
      chk("src_keep", 64'd51, reg_rd.src_sel);
      chk("dio_keep", 64'h0bad_cafe, {32'h0, dio_out});
      wr(4'h2, 64'h0);
      chk("dio_man", 64'hdead_beef, {32'h0, dio_out});
      wr(4'h6, 64'h31);
      chk("dio_seq2", 64'h2222_0002, {32'h0, dio_out});
      rst_n = 1'b0;
      @(posedge sys_clk);
      #1 chk_reset();
      wrap_up();
   end
endmodule
